// ==== src/csp_pkg.sv ====
package csp_pkg;

    // ----------------------------------------------------------------
    // clock and delay timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 40000;
    localparam int DLY_STEP_PS = 250;
    localparam int DLY_MAX_PS = 2000;
    // a step is far below one clock period, so the model gives each step one cycle
    localparam int DLY_STEP_CYC = (DLY_STEP_PS >= CLK_PERIOD_PS) ?
                                  (DLY_STEP_PS / CLK_PERIOD_PS) : 1;
    localparam int DLY_STEPS = DLY_MAX_PS / DLY_STEP_PS;
    localparam int DLY_TAPS = 2 * DLY_STEPS * DLY_STEP_CYC + 1;
    localparam int TAP_W = $clog2(DLY_TAPS);

    // ----------------------------------------------------------------
    // divider ranges
    // ----------------------------------------------------------------
    localparam int IN_DIV_MIN = 1;
    localparam int IN_DIV_MAX = 12;
    localparam int VCO_DIV_MIN = 2;
    localparam int VCO_DIV_MAX = 24;
    localparam int LOW_DIV_MIN = 2;
    localparam int LOW_DIV_MAX = 128;
    localparam int DIV_W = 8;

    // ----------------------------------------------------------------
    // shifted output phase and duty
    // ----------------------------------------------------------------
    localparam int PHASE_STEP_DEG = 45;
    localparam int PHASE_MAX_DEG = 315;
    localparam int OCTANTS = (PHASE_MAX_DEG / PHASE_STEP_DEG) + 1;
    localparam int PER_W = 16;

    // ----------------------------------------------------------------
    // loop filter and lock detect
    // ----------------------------------------------------------------
    localparam int ACC_W = 24;
    localparam logic [ACC_W-1:0] INC_RST = 24'h010000;
    localparam logic [ACC_W-1:0] INC_STEP = 24'h000040;
    localparam logic [ACC_W-1:0] INC_MAX = 24'h3FFFFF;
    localparam logic [3:0] LOCK_PULSES = 4'hF;
    localparam int VALID_TIMEOUT_CYC = 1024;
    localparam int RST_PULSE_CYC = 4;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LS_SEEK   = 3'b001,
        LS_TRACK  = 3'b010,
        LS_LOCKED = 3'b100
    } csp_lock_t;

    typedef enum logic [2:0] {
        FB_PRIMARY = 3'b001,
        FB_DIVIDED = 3'b010,
        FB_PIN     = 3'b100
    } csp_fb_src_t;

    // force a divider setting into its legal range, even-only where asked
    function automatic int clamp_div(input int v, input int lo, input int hi, input bit even);
        int r;
        r = (v < lo) ? lo : ((v > hi) ? hi : v);
        if (even && (r % 2 != 0)) begin
            r = r + 1;
        end
        return r;
    endfunction

endpackage

// ==== src/csp_link_if.sv ====
interface csp_link_if;
    logic reference_clock;
    logic feedback_clock;
    logic div_rst;
    logic delay_mode_select;
    logic delay_zero;
    logic delay_lag;
    logic [2:0] delay_step;
    logic primary_clock;
    logic shifted_clock;
    logic divided_clock;
    logic lock;
    logic delay_zero_st;
    logic delay_lag_st;
    logic [2:0] delay_step_st;

    modport dev (
        input reference_clock, feedback_clock, div_rst,
        input delay_mode_select, delay_zero, delay_lag, delay_step,
        output primary_clock, shifted_clock, divided_clock, lock,
        output delay_zero_st, delay_lag_st, delay_step_st
    );

    modport fab (
        output reference_clock, feedback_clock, div_rst,
        output delay_mode_select, delay_zero, delay_lag, delay_step,
        input primary_clock, shifted_clock, divided_clock, lock,
        input delay_zero_st, delay_lag_st, delay_step_st
    );
endinterface

// ==== src/csp_div.sv ====
module csp_div #(
    parameter int CW = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // count control
    input wire logic i_clr,
    input wire logic i_tick,
    input wire logic [CW-1:0] i_div,
    // results
    output logic o_pulse,
    output logic o_level
);
    logic [CW-1:0] cnt_q, cnt_d;
    logic pulse_q, pulse_d;
    logic level_q, level_d;

    // count ticks; every i_div-th tick pulses once and flips the level
    always_comb begin
        cnt_d = cnt_q;
        pulse_d = 1'b0;
        level_d = level_q;
        if (i_clr) begin
            cnt_d = '0;
            level_d = 1'b0;
        end else if (i_tick) begin
            if (cnt_q >= i_div - 1'b1) begin
                cnt_d = '0;
                pulse_d = 1'b1;
                level_d = ~level_q;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
            pulse_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pulse_q <= pulse_d;
            level_q <= level_d;
        end
    end

    assign o_pulse = pulse_q;
    assign o_level = level_q;
endmodule

// ==== src/csp_pll.sv ====
// How it works
// RL1 - input divider 1..12 divides the reference
// RL2 - feedback divider 1..12 multiplies the output
// RL3 - 250ps steps to 2ns, all outputs shifted
// RL4 - static delay fixed from power-up
// RL5 - dynamic delay taken from fabric-driven bus
// RL6 - vco divider even 2..24, squares duty
// RL7 - low-rate divider even 2..128 off primary
// RL8 - active-high divider reset, idle low
// RL9 - divider reset ignored when input divide is 1
// RL10 - fabric pulses shared divider reset for step
// RL11 - fabric always supplies a feedback clock
// RL12 - shifted output phase in 45 degree steps
// RL13 - shifted output duty in eighths of period
// RL14 - lock rises when locked, drops on loss
// RL15 - fixed delay step signed -8..+8
// RL16 - wake-up waits for lock when enabled
// RL17 - mode pin picks source; static ignores bus
// RL18 - reduced variant drops optional features
// RL19 - fabric uses at least one output clock
// RL20 - bus: zero, lag, 3-bit magnitude, mirrored
module csp_pll import csp_pkg::*; #(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int INPUT_DIVIDER_VALUE = 1,
    parameter int FEEDBACK_DIVIDER_VALUE = 1,
    parameter int VCO_OUTPUT_DIVIDER_VALUE = 2,
    parameter int LOW_RATE_DIVIDER_VALUE = 2,
    parameter int FIXED_DELAY_STEP = 0,
    parameter int COARSE_PHASE_SELECT = 0,
    parameter int DUTY_EIGHTHS = 4,
    parameter bit DELAY_SOURCE_DYNAMIC = 1'b0,
    parameter bit WAKE_ON_LOCK = 1'b0,
    parameter int VALID_TIMEOUT = VALID_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // link to fabric
    csp_link_if.dev lnk,
    // user side
    output logic o_vco_clock,
    output logic o_wake_done
);
    // ----------------------------------------------------------------
    // settings forced into legal range
    // ----------------------------------------------------------------
    localparam int M_DIV = clamp_div(INPUT_DIVIDER_VALUE, IN_DIV_MIN, IN_DIV_MAX, 1'b0);
    localparam int N_DIV = clamp_div(FEEDBACK_DIVIDER_VALUE, IN_DIV_MIN, IN_DIV_MAX, 1'b0);
    localparam int V_DIV = clamp_div(VCO_OUTPUT_DIVIDER_VALUE, VCO_DIV_MIN, VCO_DIV_MAX, 1'b1);
    localparam int K_DIV = clamp_div(LOW_RATE_DIVIDER_VALUE, LOW_DIV_MIN, LOW_DIV_MAX, 1'b1);
    localparam int F_DEL = (FIXED_DELAY_STEP < -DLY_STEPS) ? -DLY_STEPS :
                           ((FIXED_DELAY_STEP > DLY_STEPS) ? DLY_STEPS : FIXED_DELAY_STEP);
    localparam int PHASE = COARSE_PHASE_SELECT % OCTANTS;
    localparam int DUTY = clamp_div(DUTY_EIGHTHS, 1, OCTANTS - 1, 1'b0);
    localparam int TO_W = $clog2(VALID_TIMEOUT + 1);
    localparam bit DYN_OK = FULL_VARIANT && DELAY_SOURCE_DYNAMIC;
    // ----------------------------------------------------------------
    // input edges and dividers
    // ----------------------------------------------------------------
    logic ref_q, fb_q, vco_q, prim_q;
    logic ref_rise, fb_rise, vco_rise, prim_rise, ref_div, fb_div, prim_lvl, low_lvl, m_clr;
    logic [ACC_W-1:0] acc_q, acc_d;
    assign ref_rise = lnk.reference_clock & ~ref_q;
    assign fb_rise = lnk.feedback_clock & ~fb_q;
    assign vco_rise = acc_q[ACC_W-1] & ~vco_q;
    assign prim_rise = prim_lvl & ~prim_q;
    // reset only touches the input divider, and a divide of one has nothing to clear
    assign m_clr = FULL_VARIANT && (M_DIV != 1) && lnk.div_rst; // [RL8] [RL9] [RL10]
    // divided reference entering the phase detector
    csp_div #(.CW(DIV_W)) u_mdiv (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clr(m_clr), .i_tick(ref_rise),
        .i_div(DIV_W'(M_DIV)), .o_pulse(ref_div), .o_level()); // [RL1]
    // divided feedback; the loop speeds the vco up or slows it down until it matches the reference
    csp_div #(.CW(DIV_W)) u_ndiv (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clr(1'b0), .i_tick(fb_rise),
        .i_div(DIV_W'(N_DIV)), .o_pulse(fb_div), .o_level()); // [RL2] [RL11]
    // level flips every V/2 vco cycles, so primary is a square vco/V
    csp_div #(.CW(DIV_W)) u_vdiv (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clr(1'b0), .i_tick(vco_rise),
        .i_div(DIV_W'(V_DIV / 2)), .o_pulse(), .o_level(prim_lvl)); // [RL6]
    // low-rate clock counts primary edges
    csp_div #(.CW(DIV_W)) u_kdiv (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clr(1'b0), .i_tick(prim_rise),
        .i_div(DIV_W'(K_DIV / 2)), .o_pulse(), .o_level(low_lvl)); // [RL7]
    // ----------------------------------------------------------------
    // loop filter, validity watch and lock state
    // ----------------------------------------------------------------
    logic signed [3:0] err_q, err_d;
    logic [ACC_W-1:0] inc_q, inc_d;
    logic [3:0] lcnt_q, lcnt_d;
    logic [TO_W-1:0] ridle_q, ridle_d, fidle_q, fidle_d;
    csp_lock_t st_q, st_d;
    logic valid;
    // bang-bang loop: one ref pulse ahead is the balance point
    always_comb begin
        err_d = err_q;
        inc_d = inc_q;
        lcnt_d = lcnt_q;
        st_d = st_q;
        acc_d = acc_q + inc_q;
        ridle_d = ref_rise ? '0 : ((ridle_q == TO_W'(VALID_TIMEOUT)) ? ridle_q : ridle_q + 1'b1);
        fidle_d = fb_rise ? '0 : ((fidle_q == TO_W'(VALID_TIMEOUT)) ? fidle_q : fidle_q + 1'b1);
        valid = (ridle_q != TO_W'(VALID_TIMEOUT)) && (fidle_q != TO_W'(VALID_TIMEOUT));
        if (ref_div && !fb_div && err_q != 4'sd7) begin
            err_d = err_q + 4'sd1;
        end else if (fb_div && !ref_div && err_q != -4'sd7) begin
            err_d = err_q - 4'sd1;
        end
        if (ref_div) begin
            if (err_d > 4'sd1 && inc_q <= INC_MAX - INC_STEP) begin
                inc_d = inc_q + INC_STEP; // feedback slow: speed the vco up
            end else if (err_d < 4'sd1 && inc_q > INC_STEP) begin
                inc_d = inc_q - INC_STEP; // feedback fast: slow it down
            end
            lcnt_d = (err_d < 4'sd0 || err_d > 4'sd2) ? 4'h0 :
                     ((lcnt_q == LOCK_PULSES) ? lcnt_q : lcnt_q + 1'b1);
        end
        unique case (st_q)
            LS_SEEK: begin
                if (valid) begin
                    st_d = LS_TRACK;
                end
            end
            LS_TRACK: begin
                if (!valid) begin
                    st_d = LS_SEEK;
                end else if (lcnt_q == LOCK_PULSES) begin
                    st_d = LS_LOCKED; // [RL14]
                end
            end
            LS_LOCKED: begin
                if (!valid) begin
                    st_d = LS_SEEK; // [RL14]
                end else if (lcnt_q != LOCK_PULSES) begin
                    st_d = LS_TRACK;
                end
            end
        endcase
        // a dead reference or feedback throws away loop history
        if (!valid) begin
            err_d = '0;
            lcnt_d = '0;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ref_q <= 1'b0;
            fb_q <= 1'b0;
            vco_q <= 1'b0;
            prim_q <= 1'b0;
            acc_q <= '0;
            err_q <= '0;
            inc_q <= INC_RST;
            lcnt_q <= '0;
            ridle_q <= '0;
            fidle_q <= '0;
            st_q <= LS_SEEK;
        end else begin
            ref_q <= lnk.reference_clock;
            fb_q <= lnk.feedback_clock;
            vco_q <= acc_q[ACC_W-1];
            prim_q <= prim_lvl;
            acc_q <= acc_d;
            err_q <= err_d;
            inc_q <= inc_d;
            lcnt_q <= lcnt_d;
            ridle_q <= ridle_d;
            fidle_q <= fidle_d;
            st_q <= st_d;
        end
    end
    // ----------------------------------------------------------------
    // shifted output: phase and duty in eighths of the primary period
    // ----------------------------------------------------------------
    logic [PER_W-1:0] pos_q, pos_d, per_q, per_d;
    logic [2:0] rel;
    logic shift_raw;
    // octant of pos within per, by compare rather than divide
    function automatic logic [2:0] octant(input logic [PER_W-1:0] pos,
                                         input logic [PER_W-1:0] per);
        logic [2:0] o;
        logic [PER_W+2:0] p8;
        logic [PER_W+2:0] pk;
        o = 3'h0;
        p8 = {pos, 3'h0};
        for (int k = 1; k < OCTANTS; k++) begin
            pk = (PER_W + 3)'(per) * (PER_W + 3)'(k);
            if (p8 >= pk) begin
                o = 3'(k);
            end
        end
        return o;
    endfunction
    // period is measured, so the shape follows the loop as it settles
    always_comb begin
        pos_d = prim_rise ? '0 : ((&pos_q) ? pos_q : pos_q + 1'b1);
        per_d = prim_rise ? pos_q + 1'b1 : per_q;
        rel = octant(pos_q, per_q) - 3'(PHASE); // [RL12]
        shift_raw = FULL_VARIANT && ({1'b0, rel} < 4'(DUTY)); // [RL13] [RL18]
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pos_q <= '0;
            per_q <= '0;
        end else begin
            pos_q <= pos_d;
            per_q <= per_d;
        end
    end
    // ----------------------------------------------------------------
    // delay source and common delay line
    // ----------------------------------------------------------------
    logic zero_q, zero_d, lag_q, lag_d, wake_q, wake_d;
    logic [2:0] mag_q, mag_d, out_q, out_d;
    logic signed [4:0] step_q, step_d;
    logic [2:0] dly_q [DLY_TAPS];
    logic [TAP_W-1:0] tap;
    // the middle tap is nominal, so leading is just a shorter path
    always_comb begin
        if (DYN_OK && lnk.delay_mode_select) begin // [RL5] [RL17]
            zero_d = lnk.delay_zero; // [RL20]
            lag_d = lnk.delay_lag;
            mag_d = lnk.delay_step;
            step_d = lnk.delay_zero ? 5'sd0 :
                     (lnk.delay_lag ? 5'(lnk.delay_step) + 5'sd1 : -5'(lnk.delay_step) - 5'sd1);
        end else begin
            step_d = 5'(F_DEL); // [RL4] [RL15]
            zero_d = (F_DEL == 0);
            lag_d = (F_DEL > 0);
            mag_d = (F_DEL == 0) ? 3'h0 : 3'((F_DEL > 0 ? F_DEL : -F_DEL) - 1);
        end
        tap = TAP_W'((DLY_STEPS + int'(step_q)) * DLY_STEP_CYC);
        out_d = dly_q[tap]; // [RL3]
        wake_d = wake_q || !WAKE_ON_LOCK || (st_q == LS_LOCKED); // [RL16]
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            zero_q <= 1'b1;
            lag_q <= 1'b0;
            mag_q <= '0;
            step_q <= '0;
            out_q <= '0;
            wake_q <= 1'b0;
            for (int i = 0; i < DLY_TAPS; i++) begin
                dly_q[i] <= '0;
            end
        end else begin
            zero_q <= zero_d;
            lag_q <= lag_d;
            mag_q <= mag_d;
            step_q <= step_d;
            out_q <= out_d;
            wake_q <= wake_d;
            dly_q[0] <= {low_lvl & FULL_VARIANT, shift_raw, prim_lvl}; // [RL18]
            for (int i = 1; i < DLY_TAPS; i++) begin
                dly_q[i] <= dly_q[i-1];
            end
        end
    end
    // outputs
    assign lnk.primary_clock = out_q[0];
    assign lnk.shifted_clock = out_q[1];
    assign lnk.divided_clock = out_q[2];
    assign lnk.lock = (st_q == LS_LOCKED);
    assign lnk.delay_zero_st = zero_q;
    assign lnk.delay_lag_st = lag_q;
    assign lnk.delay_step_st = mag_q;
    assign o_vco_clock = vco_q;
    assign o_wake_done = wake_q;
endmodule

// ==== src/csp_fabric.sv ====
module csp_fabric import csp_pkg::*; #(
    parameter int REF_HALF = 20,
    parameter csp_fb_src_t FB_SEL = FB_PRIMARY
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // link to the loop
    csp_link_if.fab lnk,
    // user control
    input wire logic i_sync_req,
    input wire logic i_fb_pin,
    input wire logic i_dyn_mode,
    input wire logic i_dyn_zero,
    input wire logic i_dyn_lag,
    input wire logic [2:0] i_dyn_step,
    // user results
    output logic o_primary,
    output logic o_shifted,
    output logic o_divided,
    output logic o_lock,
    output logic o_delay_zero,
    output logic o_delay_lag,
    output logic [2:0] o_delay_step
);
    localparam int HW = $clog2(REF_HALF + 1);

    logic [HW-1:0] hcnt_q, hcnt_d;
    logic ref_q, ref_d, fb_q, fb_d;
    logic [2:0] rcnt_q, rcnt_d;
    logic rst_q, rst_d;
    logic mode_q, zero_q, lag_q;
    logic [2:0] step_q;
    logic [5:0] obs_q;

    // ----------------------------------------------------------------
    // reference, feedback and divider reset
    // ----------------------------------------------------------------
    // one request pulses the reset for a few cycles so every loop sees it
    always_comb begin
        hcnt_d = hcnt_q + 1'b1;
        ref_d = ref_q;
        if (hcnt_q == HW'(REF_HALF - 1)) begin
            hcnt_d = '0;
            ref_d = ~ref_q;
        end
        unique case (FB_SEL)
            FB_PRIMARY: fb_d = lnk.primary_clock; // [RL11] [RL19]
            FB_DIVIDED: fb_d = lnk.divided_clock;
            FB_PIN: fb_d = i_fb_pin;
        endcase
        rcnt_d = (rcnt_q != 3'h0) ? rcnt_q - 3'h1 : 3'h0;
        if (i_sync_req) begin
            rcnt_d = 3'(RST_PULSE_CYC); // [RL10]
        end
        rst_d = (rcnt_d != 3'h0); // [RL8]
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hcnt_q <= '0;
            ref_q <= 1'b0;
            fb_q <= 1'b0;
            rcnt_q <= '0;
            rst_q <= 1'b0;
            mode_q <= 1'b0;
            zero_q <= 1'b1;
            lag_q <= 1'b0;
            step_q <= '0;
            obs_q <= '0;
        end else begin
            hcnt_q <= hcnt_d;
            ref_q <= ref_d;
            fb_q <= fb_d;
            rcnt_q <= rcnt_d;
            rst_q <= rst_d;
            // dynamic delay bus is a plain registered copy of the user inputs
            mode_q <= i_dyn_mode; // [RL5] [RL20]
            zero_q <= i_dyn_zero;
            lag_q <= i_dyn_lag;
            step_q <= i_dyn_step;
            obs_q <= {lnk.delay_step_st, lnk.delay_lag_st, lnk.delay_zero_st, lnk.lock};
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign lnk.reference_clock = ref_q;
    assign lnk.feedback_clock = fb_q;
    assign lnk.div_rst = rst_q;
    assign lnk.delay_mode_select = mode_q;
    assign lnk.delay_zero = zero_q;
    assign lnk.delay_lag = lag_q;
    assign lnk.delay_step = step_q;
    // clocks pass straight through; a flop would only add skew to them
    assign o_primary = lnk.primary_clock;
    assign o_shifted = lnk.shifted_clock;
    assign o_divided = lnk.divided_clock;
    assign o_lock = obs_q[0];
    assign o_delay_zero = obs_q[1];
    assign o_delay_lag = obs_q[2];
    assign o_delay_step = obs_q[5:3];
endmodule

// ==== bench/csp_pll_checker.sv ====
module csp_pll_checker (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // link signals
    input wire logic reference_clock,
    input wire logic feedback_clock,
    input wire logic div_rst,
    input wire logic delay_mode_select,
    input wire logic delay_zero,
    input wire logic delay_lag,
    input wire logic [2:0] delay_step,
    input wire logic lock,
    input wire logic delay_zero_st,
    input wire logic delay_lag_st,
    input wire logic [2:0] delay_step_st
);
    // ------------------------------------------------------------
    // link properties, all on the one clock
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // divider reset is a clean four-cycle pulse
    property p_rst_pulse;
        $rose(div_rst) |-> div_rst [*4] ##1 !div_rst;
    endproperty
    property p_rst_min;
        $fell(div_rst) |-> $past(div_rst, 4);
    endproperty
    // dynamic bus is taken one cycle after it is seen
    property p_dyn_take;
        delay_mode_select && !delay_zero |=> !delay_zero_st && delay_lag_st == $past(delay_lag)
            && delay_step_st == $past(delay_step);
    endproperty
    property p_zero_wins;
        delay_mode_select && delay_zero |=> delay_zero_st;
    endproperty
    // static mode applies the fixed step (zero here), whatever the bus says
    property p_static;
        !delay_mode_select |=> delay_zero_st;
    endproperty
    property p_lock_reset;
        $rose(i_rst_n) |-> !lock;
    endproperty
    property p_ref_alive;
        $rose(reference_clock) |-> ##128 $fell(reference_clock);
    endproperty
    property p_fb_alive;
        lock |-> ##[1:400] $changed(feedback_clock);
    endproperty

    a_rst_pulse: assert property (p_rst_pulse) else $error("div reset width");
    a_rst_min: assert property (p_rst_min) else $error("div reset short");
    a_dyn_take: assert property (p_dyn_take) else $error("dynamic delay");
    a_zero_wins: assert property (p_zero_wins) else $error("zero flag");
    a_static: assert property (p_static) else $error("static delay");
    a_lock_reset: assert property (p_lock_reset) else $error("lock at reset");
    a_ref_alive: assert property (p_ref_alive) else $error("reference stuck");
    a_fb_alive: assert property (p_fb_alive) else $error("feedback stuck");

    c_lock: cover property ($rose(lock));
    c_sync: cover property ($rose(div_rst));
    c_lag: cover property (delay_mode_select && delay_lag && !delay_zero);
endmodule

// ==== bench/csp_pll_tb.sv ====
module csp_pll_tb import csp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // stimulus and instances
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic sync = 1'b0;
    logic mode = 1'b0;
    logic zero = 1'b1;
    logic lag = 1'b0;
    logic [2:0] step = 3'h0;
    logic o_primary, o_shifted, o_divided, o_lock, o_delay_zero, o_delay_lag, o_wake_done;
    logic [2:0] o_delay_step;
    logic o_vco_clock;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    csp_link_if lnk ();

    always #20 i_clk = ~i_clk;

    // divided reference starts level with the free-running primary, so lock comes early
    csp_pll #(.INPUT_DIVIDER_VALUE(2), .LOW_RATE_DIVIDER_VALUE(4), .DELAY_SOURCE_DYNAMIC(1'b1),
        .WAKE_ON_LOCK(1'b1)) i_csp_pll (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .lnk(lnk.dev), .o_vco_clock(o_vco_clock), .o_wake_done(o_wake_done));
    csp_fabric #(.REF_HALF(128)) i_csp_fabric (.i_clk(i_clk), .i_rst_n(i_rst_n), .lnk(lnk.fab),
        .i_sync_req(sync), .i_fb_pin(o_divided), .i_dyn_mode(mode), .i_dyn_zero(zero),
        .i_dyn_lag(lag), .i_dyn_step(step), .o_primary(o_primary), .o_shifted(o_shifted),
        .o_divided(o_divided), .o_lock(o_lock), .o_delay_zero(o_delay_zero),
        .o_delay_lag(o_delay_lag), .o_delay_step(o_delay_step));
    csp_pll_checker i_csp_pll_checker (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .reference_clock(lnk.reference_clock), .feedback_clock(lnk.feedback_clock),
        .div_rst(lnk.div_rst), .delay_mode_select(lnk.delay_mode_select),
        .delay_zero(lnk.delay_zero), .delay_lag(lnk.delay_lag), .delay_step(lnk.delay_step),
        .lock(lnk.lock), .delay_zero_st(lnk.delay_zero_st), .delay_lag_st(lnk.delay_lag_st),
        .delay_step_st(lnk.delay_step_st));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [4:0] seen, input logic [4:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // bus goes out through two flops, status back through one more
    task automatic set_bus(input logic m, input logic z, input logic l, input logic [2:0] s);
        @(posedge i_clk);
        mode <= m;
        zero <= z;
        lag <= l;
        step <= s;
        repeat (4) @(posedge i_clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        check({lnk.delay_zero_st, lnk.delay_lag_st, lnk.delay_step_st}, 5'h10);
        check({3'h0, o_lock, o_wake_done}, 5'h00);
    endtask

    task automatic t_sync();
        @(posedge i_clk);
        sync <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            sync <= 1'b0;
            #1 check({4'h0, lnk.div_rst}, 5'h01);
        end
        @(posedge i_clk);
        #1 check({4'h0, lnk.div_rst}, 5'h00);
    endtask

    // every magnitude in both directions, back to back
    task automatic t_dyn_sweep();
        for (int l = 0; l < 2; l++) begin
            for (int s = 0; s < 8; s++) begin
                set_bus(1'b1, 1'b0, l[0], s[2:0]);
                check({o_delay_zero, o_delay_lag, o_delay_step}, {1'b0, l[0], s[2:0]});
            end
        end
    endtask

    task automatic t_zero_and_static();
        set_bus(1'b1, 1'b1, 1'b1, 3'h7);
        check({4'h0, o_delay_zero}, 5'h01);
        // a live bus value while static must not reach the status
        set_bus(1'b0, 1'b0, 1'b1, 3'h5);
        check({4'h0, o_delay_zero}, 5'h01);
    endtask

    task automatic t_lock_wake();
        int n;
        for (n = 0; n < 50000 && o_lock !== 1'b1; n++) begin
            @(posedge i_clk);
        end
        repeat (2) @(posedge i_clk);
        #1 check({3'h0, lnk.lock, o_wake_done}, 5'h03);
    endtask

    // one divided period holds K primary, K shifted and 2K vco rises
    task automatic t_clocks();
        int n [4];
        logic [3:0] prev;
        logic [3:0] now;
        n = '{0, 0, 0, 0};
        prev = 4'hF;
        while (n[3] < 2) begin
            @(posedge i_clk);
            #1 now = {o_divided, o_vco_clock, o_shifted, o_primary};
            for (int i = 0; i < 4; i++) begin
                n[i] += (now[i] && !prev[i] && (i == 3 || n[3] == 1)) ? 1 : 0;
            end
            prev = now;
        end
        check(5'(n[0]), 5'h04);
        check(5'(n[1]), 5'h04);
        check(5'(n[2]), 5'h08);
    endtask

    // ------------------------------------------------------------
    // run and hang guard
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        #1 t_reset_values();
        t_sync();
        t_dyn_sweep();
        t_zero_and_static();
        t_lock_wake();
        t_clocks();
        end_of_test();
    end
endmodule
